/* grayscale_pwm_engine.v */
// Grayscale PWM engine with APB register access and 16 sink outputs
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "gs_engine_regs.vh"

module grayscale_pwm_engine (
  input wire mclk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire gray_ref_clock,
  input wire latch_strobe,
  output reg [15:0] sink_output_channel
);

  // Reset release synchroniser
  reg rstn_meta_r;
  reg rstn_sync_r;

  // Pin synchronisers and edge detectors
  reg gclk_meta_r;
  reg gclk_sync_r;
  reg gclk_prev_r;
  reg lat_meta_r;
  reg lat_sync_r;
  reg lat_prev_r;
  wire gclk_rise;
  wire lat_rise;

  // Control bits
  reg blank_r;
  reg spread_r;
  reg tmg_rst_r;
  reg auto_rpt_r;

  // Grayscale latches: first written by software, second drives the outputs
  reg [15:0] gs_first_r [0:15];
  reg [15:0] gs_second_r [0:15];

  // Engine state
  reg [15:0] cnt_r;
  reg [15:0] cnt_nxt;
  reg done_r;
  reg done_nxt;
  reg [15:0] out_nxt;
  reg [15:0] restart_cnt_r;
  wire [15:0] slot_on;
  wire running;

  // APB decode
  wire apb_setup;
  wire apb_write;
  wire hit_ctrl;
  wire hit_status;
  wire hit_live;
  wire hit_gs;
  wire hit_any;
  wire [3:0] gs_idx;
  reg [31:0] rd_mux;

  // Asynchronous assert, synchronous release of the internal reset
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rstn_meta_r <= 1'b0;
      rstn_sync_r <= 1'b0;
    end else begin
      rstn_meta_r <= 1'b1;
      rstn_sync_r <= rstn_meta_r;
    end
  end

  // Two synchroniser flops and one delay flop on each pin, edge found on the second stage only
  always @(posedge mclk or negedge rstn_sync_r) begin
    if (!rstn_sync_r) begin
      gclk_meta_r <= 1'b0;
      gclk_sync_r <= 1'b0;
      gclk_prev_r <= 1'b0;
      lat_meta_r <= 1'b0;
      lat_sync_r <= 1'b0;
      lat_prev_r <= 1'b0;
    end else begin
      gclk_meta_r <= gray_ref_clock;
      gclk_sync_r <= gclk_meta_r;
      gclk_prev_r <= gclk_sync_r;
      lat_meta_r <= latch_strobe;
      lat_sync_r <= lat_meta_r;
      lat_prev_r <= lat_sync_r;
    end
  end

  assign gclk_rise = gclk_sync_r & ~gclk_prev_r;
  assign lat_rise = lat_sync_r & ~lat_prev_r;

  // Address decode of the register window
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pready & pwrite;
  assign hit_ctrl = (paddr == `REG_CTRL);
  assign hit_status = (paddr == `REG_STATUS);
  assign hit_live = (paddr == `REG_LIVE);
  assign hit_gs = (paddr >= `REG_GS_BASE) && (paddr < (`REG_GS_BASE + `REG_GS_SPAN)) && (paddr[1:0] == 2'b00);
  assign hit_any = hit_ctrl | hit_status | hit_live | hit_gs;
  assign gs_idx = paddr[5:2];
  assign running = ~blank_r & ~done_r;

  // Read data selection, unmapped reads return zero
  always @* begin
    rd_mux = 32'h00000000;
    if (hit_ctrl) begin
      rd_mux[`CTRL_BLANK] = blank_r;
      rd_mux[`CTRL_SPREAD] = spread_r;
      rd_mux[`CTRL_TMG_RST] = tmg_rst_r;
      rd_mux[`CTRL_AUTO_RPT] = auto_rpt_r;
    end else if (hit_status) begin
      rd_mux[15:0] = cnt_r;
      rd_mux[`STAT_DONE] = done_r;
      rd_mux[`STAT_RUN] = running;
    end else if (hit_live) begin
      rd_mux[15:0] = sink_output_channel;
      rd_mux[31:16] = restart_cnt_r;
    end else if (hit_gs) begin
      rd_mux[15:0] = gs_first_r[gs_idx];
    end
  end

  // Answer one cycle after setup: zero wait states, error on unmapped address
  always @(posedge mclk or negedge rstn_sync_r) begin
    if (!rstn_sync_r) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (apb_setup) begin
      pready <= 1'b1;
      pslverr <= ~hit_any;
      prdata <= pwrite ? 32'h00000000 : rd_mux;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end

  // Control register; blank comes up set
  always @(posedge mclk or negedge rstn_sync_r) begin
    if (!rstn_sync_r) begin
      blank_r <= 1'b1;
      spread_r <= 1'b0;
      tmg_rst_r <= 1'b0;
      auto_rpt_r <= 1'b0;
    end else if (apb_write && hit_ctrl) begin
      blank_r <= pwdata[`CTRL_BLANK];
      spread_r <= pwdata[`CTRL_SPREAD];
      tmg_rst_r <= pwdata[`CTRL_TMG_RST];
      auto_rpt_r <= pwdata[`CTRL_AUTO_RPT];
    end
  end

  // Per channel: software writes first latch, strobe copies it to the second
  genvar ch;
  generate
    for (ch = 0; ch < `CHANNELS; ch = ch + 1) begin : g_chan
      always @(posedge mclk or negedge rstn_sync_r) begin
        if (!rstn_sync_r) begin
          gs_first_r[ch] <= `GS_RESET;
          gs_second_r[ch] <= `GS_RESET;
        end else begin
          if (apb_write && hit_gs && (gs_idx == ch)) begin
            gs_first_r[ch] <= pwdata[15:0];
          end
          if (lat_rise) begin
            gs_second_r[ch] <= gs_first_r[ch];
          end
        end
      end

      gs_slot_compare u_cmp (
        .grayscale_value(gs_second_r[ch]),
        .slot(cnt_r),
        .spectrum_mode_select(spread_r),
        .slot_on(slot_on[ch])
      );
    end
  endgenerate

  // Counter, end-of-period and output next state; blank beats the rest
  always @* begin
    cnt_nxt = cnt_r;
    done_nxt = done_r;
    out_nxt = sink_output_channel;
    if (blank_r) begin
      cnt_nxt = 16'h0000;
      done_nxt = 1'b0;
      out_nxt = 16'h0000;
    end else if (lat_rise && tmg_rst_r) begin
      cnt_nxt = 16'h0000;
      done_nxt = 1'b0;
      out_nxt = 16'h0000;
    end else if (gclk_rise && !done_r) begin
      if (cnt_r == `CNT_LAST) begin
        cnt_nxt = 16'h0000;
        out_nxt = 16'h0000;
        done_nxt = ~auto_rpt_r;
      end else begin
        cnt_nxt = cnt_r + 16'h0001;
        out_nxt = slot_on;
      end
    end
  end

  // Engine registers; outputs come straight from flops
  always @(posedge mclk or negedge rstn_sync_r) begin
    if (!rstn_sync_r) begin
      cnt_r <= 16'h0000;
      done_r <= 1'b0;
      sink_output_channel <= 16'h0000;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
      sink_output_channel <= out_nxt;
    end
  end

  // Count of internal restarts, timing reset and auto-repeat alike
  always @(posedge mclk or negedge rstn_sync_r) begin
    if (!rstn_sync_r) begin
      restart_cnt_r <= 16'h0000;
    end else if (!blank_r) begin
      if ((lat_rise && tmg_rst_r) || (gclk_rise && !done_r && (cnt_r == `CNT_LAST) && auto_rpt_r)) begin
        restart_cnt_r <= restart_cnt_r + 16'h0001;
      end
    end
  end

endmodule // grayscale_pwm_engine
`default_nettype wire

/* gs_engine_regs.vh */
// Register map, field positions and reset values of the grayscale engine
`ifndef GS_ENGINE_REGS_VH
`define GS_ENGINE_REGS_VH

// Byte offsets of the APB registers
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_LIVE 12'h008
`define REG_GS_BASE 12'h040
`define REG_GS_SPAN 12'h040

// Control register fields
`define CTRL_BLANK 0
`define CTRL_SPREAD 1
`define CTRL_TMG_RST 2
`define CTRL_AUTO_RPT 3
`define CTRL_WIDTH 4
`define CTRL_RESET 4'h1

// Status register fields
`define STAT_CNT_LSB 0
`define STAT_DONE 16
`define STAT_RUN 17

// Counter and segment geometry
`define CNT_LAST 16'hFFFF
`define SEG_POS_BITS 9
`define SEG_IDX_BITS 7
`define GS_RESET 16'h0000
`define CHANNELS 16

`endif

/* gs_slot_compare.v */
// Per-channel on/off decision for one reference clock slot of the period
`timescale 1ns/1ps
`default_nettype none
`include "gs_engine_regs.vh"

module gs_slot_compare (
  input wire [15:0] grayscale_value,
  input wire [15:0] slot,
  input wire spectrum_mode_select,
  output wire slot_on
);

  wire [6:0] seg_idx;
  wire [8:0] seg_pos;
  wire [6:0] seg_rank;
  wire [8:0] base_clocks;
  wire [6:0] extra_ranks;
  wire [9:0] seg_clocks;
  wire single_on;
  wire spread_on;

  // Slot splits into segment number and position inside the segment
  assign seg_idx = slot[15:9];
  assign seg_pos = slot[8:0];

  // Bit reversal of the segment number gives its rank in the scrambled order
  genvar b;
  generate
    for (b = 0; b < 7; b = b + 1) begin : g_rev
      assign seg_rank[b] = seg_idx[6 - b];
    end
  endgenerate

  // Every segment gets value/128 clocks, low ranks get one clock more
  assign base_clocks = grayscale_value[15:7];
  assign extra_ranks = grayscale_value[6:0];
  assign seg_clocks = {1'b0, base_clocks} + {9'h000, (seg_rank < extra_ranks)};

  // Single pulse: on while slot index below value, so on-time is value clocks
  assign single_on = (slot < grayscale_value);
  assign spread_on = ({1'b0, seg_pos} < seg_clocks);

  // Mode bit chooses the drive scheme
  assign slot_on = spectrum_mode_select ? spread_on : single_on;

endmodule // gs_slot_compare
`default_nettype wire

/* gs_engine_sva.sv */
// Port checker for the grayscale engine
`timescale 1ns/1ps
`default_nettype none
`include "gs_engine_regs.vh"
module gs_engine_sva (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic gray_ref_clock,
  input wire logic [15:0] sink_output_channel
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  logic gd_r;
  logic [3:0] since_r;
  // Clocks since the last reference pin rise
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      gd_r <= 1'b0;
      since_r <= 4'hF;
    end else begin
      gd_r <= gray_ref_clock;
      if (gray_ref_clock && !gd_r) since_r <= 4'h0;
      else if (since_r != 4'hF) since_r <= since_r + 4'h1;
    end
  end
  sequence s_setup; psel && !penable; endsequence
  sequence s_blank_wr; psel && penable && pready && pwrite && paddr == `REG_CTRL && pwdata[0]; endsequence
  property p_answer; s_setup |=> pready; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_rzero; !pready || pwrite |-> prdata == 32'h0; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_blank_wr; s_blank_wr |=> ##[0:2] sink_output_channel == 16'h0000; endproperty
  property p_blank_rd; pready && !pwrite && paddr == `REG_CTRL && prdata[0] |-> !sink_output_channel; endproperty
  property p_reset; $rose(rstn) |-> (sink_output_channel == 16'h0000) [*4]; endproperty
  property p_on; (sink_output_channel & ~$past(sink_output_channel)) != 16'h0 |-> since_r inside {[1:6]}; endproperty
  a_answer: assert property (p_answer) else $error("no ready after setup");
  a_one: assert property (p_one) else $error("ready too long");
  a_rzero: assert property (p_rzero) else $error("read data not zero");
  a_err: assert property (p_err) else $error("error without ready");
  a_blank_wr: assert property (p_blank_wr) else $error("lit after blank");
  a_blank_rd: assert property (p_blank_rd) else $error("lit while blank");
  a_reset: assert property (p_reset) else $error("lit after reset");
  a_on: assert property (p_on) else $error("lit without edge");
endmodule // gs_engine_sva
bind grayscale_pwm_engine gs_engine_sva u_sva (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .gray_ref_clock(gray_ref_clock), .sink_output_channel(sink_output_channel));
`default_nettype wire

/* gs_host_pins.sv */
// Host side pins: reference clock and latch pulses
`timescale 1ns/1ps
`default_nettype none
module gs_host_pins (
  input wire logic mclk,
  output var logic gclk,
  output var logic lat
);
  // Both lines idle low, through reset too
  initial begin
    gclk = 1'b0;
    lat = 1'b0;
  end
  // One pulse, three clocks high and three low
  task automatic pulse(input logic sel);
    if (sel) lat <= 1'b1;
    else gclk <= 1'b1;
    repeat (3) @(posedge mclk);
    gclk <= 1'b0;
    lat <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
endmodule // gs_host_pins
`default_nettype wire

/* grayscale_pwm_engine_bench.sv */
// Self-checking bench for the grayscale engine
`timescale 1ns/1ps
`default_nettype none
`include "gs_engine_regs.vh"
module grayscale_pwm_engine_bench;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready;
  logic pslverr;
  logic err;
  wire gclk;
  wire lat;
  logic [15:0] sink;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  logic [15:0] gsv [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'hFFFF};
  logic [15:0] conv [4] = '{16'h001E, 16'h001C, 16'h0018, 16'h0010};
  gs_host_pins i_host (.mclk(mclk), .gclk(gclk), .lat(lat));
  grayscale_pwm_engine i_dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gray_ref_clock(gclk), .latch_strobe(lat), .sink_output_channel(sink));
  initial begin
    forever #2 mclk = ~mclk;
  end
  task automatic close_out();
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Hang limit
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Wait for the slave; only the hang limit ends a stall
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h00000000;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    apb(1'b0, `REG_CTRL, 32'h0);
    chk("ctrl", 32'h1, q);
    chk("out", 32'h0, {16'h0, sink});
    apb(1'b0, 12'h100, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    $display("reset test done");
    // Load first latches, copy to second, then unblank
    for (int n = 0; n < 5; n++) apb(1'b1, `REG_GS_BASE + 12'(4 * n), {16'h0, gsv[n]});
    i_host.pulse(1'b1);
    apb(1'b1, `REG_CTRL, 32'h0);
    for (int k = 0; k < 4; k++) begin
      i_host.pulse(1'b0);
      chk("conv", {16'h0, conv[k]}, {16'h0, sink});
      apb(1'b0, `REG_STATUS, 32'h0);
      chk("count", 32'(k + 1), {16'h0, q[15:0]});
    end
    $display("single pulse test done");
    apb(1'b1, `REG_CTRL, 32'h1);
    i_host.pulse(1'b0);
    chk("blank out", 32'h0, {16'h0, sink});
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("blank count", 32'h0, {16'h0, q[15:0]});
    apb(1'b1, `REG_CTRL, 32'h2);
    i_host.pulse(1'b0);
    chk("seg1", 32'h1E, {16'h0, sink});
    i_host.pulse(1'b0);
    chk("seg2", 32'h10, {16'h0, sink});
    $display("segmented test done");
    apb(1'b1, `REG_CTRL, 32'hE);
    i_host.pulse(1'b1);
    chk("tmg out", 32'h0, {16'h0, sink});
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("tmg count", 32'h0, {16'h0, q[15:0]});
    chk("tmg run", 32'h00020000, q);
    i_host.pulse(1'b0);
    chk("restart", 32'h1E, {16'h0, sink});
    apb(1'b0, `REG_LIVE, 32'h0);
    chk("live", 32'h0001001E, q);
    apb(1'b0, `REG_CTRL, 32'h0);
    chk("ctrl back", 32'hE, q);
    apb(1'b0, `REG_GS_BASE + 12'h004, 32'h0);
    chk("gs back", 32'h1, q);
    $display("restart test done");
    // Mid-run reset brings blank back and clears the count
    rstn <= 1'b0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("rst out", 32'h0, {16'h0, sink});
    apb(1'b0, `REG_CTRL, 32'h0);
    chk("rst ctrl", 32'h1, q);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("rst status", 32'h0, q);
    $display("second reset test done");
    close_out();
  end
endmodule // grayscale_pwm_engine_bench
`default_nettype wire
